/* src/lv_monitor_pkg.sv */
// constants shared by the supply voltage monitor design
package lv_monitor_pkg;
  // bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  // register byte offsets
  localparam logic [3:0] STATUS_OFF = 4'h0;
  localparam logic [3:0] CONFIG_OFF = 4'h4;
  localparam logic [3:0] EVENT_OFF = 4'h8;
  localparam logic [3:0] MASK_OFF = 4'hC;
  // status field positions
  localparam int ST_FLAG_BIT = 0;
  localparam int ST_RESET_BIT = 1;
  // config field positions and reset values
  localparam int CFG_POWER_BIT = 0;
  localparam int CFG_RESET_BIT = 1;
  localparam int CFG_STOP_BIT = 2;
  localparam logic CFG_POWER_RST = 1'b1;
  localparam logic CFG_RESET_RST = 1'b1;
  localparam logic CFG_STOP_RST = 1'b0;
  // event field positions and mask reset value
  localparam int EV_FLAG_BIT = 0;
  localparam int EV_RESET_BIT = 1;
  localparam logic [1:0] MASK_RST = 2'h0;
  // rate dividers in aclk cycles
  localparam int CPU_DIV = 4;
  localparam int XTAL_DIV = 2;
  // filter lengths
  localparam int FILT_CYCLES = 9;
  localparam int FLAG_MIN_TICKS = 32;
  localparam int FLAG_MAX_TICKS = 40;
  localparam int FLAG_TICKS = (FLAG_MIN_TICKS + FLAG_MAX_TICKS) / 2;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : lv_monitor_pkg

/* src/sync_two_ff.sv */
// two flip-flop synchroniser, one chain per bit
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // asynchronous in, synchronous out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_r;
      logic stable_r;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta_r <= 1'b0;
          stable_r <= 1'b0;
        end else begin
          meta_r <= async_in[i];
          stable_r <= meta_r;
        end
      end
      assign sync_out[i] = stable_r;
    end
  endgenerate
endmodule : sync_two_ff
`default_nettype wire

/* src/run_filter.sv */
// consecutive-tick filter: reached after THRESH ticks with cond held
`timescale 1ns/1ps
`default_nettype none
module run_filter #(
  parameter int THRESH = 9,
  parameter int CW = 6
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // count control
  input wire logic enable,
  input wire logic tick,
  input wire logic cond,
  // result
  output logic reached
);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  wire at_top = (cnt_r == CW'(THRESH));
  wire restart = !enable || !cond;

  assign cnt_nxt = restart ? '0 :
                   (tick && !at_top) ? cnt_r + 1'b1 : cnt_r;
  assign reached = at_top;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  restart_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !cond |=> cnt_r == '0) else $error("filter count did not restart");
endmodule : run_filter
`default_nettype wire

/* src/lv_monitor.sv */
// supply voltage monitor: trip filter, reset hold, status flag, registers
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module lv_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [lv_monitor_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [lv_monitor_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [lv_monitor_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [lv_monitor_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  // analog comparator, asynchronous
  input wire logic below_falling_trip,
  input wire logic above_rising_trip,
  // low power mode from the core
  input wire logic stop_mode,
  // system reset request and reset pin
  output logic lowvolt_reset,
  output logic reset_pin_o,
  output logic reset_pin_oe,
  // event interrupt
  output logic event_irq
);
  import lv_monitor_pkg::*;

  // comparator synchronisation
  logic [1:0] cmp_s;
  sync_two_ff #(.W(2)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({above_rising_trip, below_falling_trip}),
    .sync_out(cmp_s)
  );
  wire below_s = cmp_s[0];
  wire above_s = cmp_s[1];

  // rate dividers for cpu cycle and crystal clock
  logic [2:0] cpu_div_r;
  logic [2:0] xtal_div_r;
  wire cpu_tick = (cpu_div_r == 3'(CPU_DIV - 1));
  wire xtal_tick = (xtal_div_r == 3'(XTAL_DIV - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_div_r <= 3'h0;
      xtal_div_r <= 3'h0;
    end else begin
      cpu_div_r <= cpu_tick ? 3'h0 : cpu_div_r + 3'h1;
      xtal_div_r <= xtal_tick ? 3'h0 : xtal_div_r + 3'h1;
    end
  end

  // configuration and state registers
  logic cfg_power_r;
  logic cfg_reset_r;
  logic cfg_stop_r;
  logic lvrst_r;
  logic flag_r;
  logic [1:0] event_r;
  logic [1:0] mask_r;

  // monitor activity; wait mode does not gate it
  wire active = cfg_power_r &&
                (!stop_mode || cfg_stop_r);
  wire rst_gen = cfg_power_r && cfg_reset_r;

  // cpu-cycle filter, cleared while cpu clocks stop
  logic filt_hit;
  run_filter #(.THRESH(FILT_CYCLES), .CW(4)) u_trip (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(active && !stop_mode && !lvrst_r),
    .tick(cpu_tick),
    .cond(below_s),
    .reached(filt_hit)
  );
  wire stop_hit = stop_mode && active && below_s;
  wire trip = (filt_hit && active && !stop_mode) || stop_hit;

  // low voltage reset set and release
  wire release_ok = cpu_tick && above_s;
  wire lvrst_nxt = lvrst_r ? !release_ok : (trip && rst_gen);

  // crystal-timed status flag filter
  logic flag_hit;
  run_filter #(.THRESH(FLAG_TICKS), .CW(6)) u_flag (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(active && !lvrst_r),
    .tick(xtal_tick),
    .cond(below_s),
    .reached(flag_hit)
  );
  wire flag_nxt = lvrst_r ? 1'b0 :
                  above_s ? 1'b0 :
                  flag_hit ? 1'b1 : flag_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvrst_r <= 1'b0;
      flag_r <= 1'b0;
      reset_pin_oe <= 1'b0;
      reset_pin_o <= 1'b1;
    end else begin
      lvrst_r <= lvrst_nxt;
      flag_r <= flag_nxt;
      reset_pin_oe <= lvrst_nxt;
      reset_pin_o <= !lvrst_nxt;
    end
  end
  assign lowvolt_reset = lvrst_r;

  // write channel: address and data taken together
  logic awready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  wire wr_go = awvalid && wvalid && !awready_r && !bvalid_r;
  wire wr_cfg = (awaddr == CONFIG_OFF);
  wire wr_evt = (awaddr == EVENT_OFF);
  wire wr_msk = (awaddr == MASK_OFF);
  wire wr_sts = (awaddr == STATUS_OFF);
  wire wr_map = wr_cfg || wr_evt || wr_msk || wr_sts;
  wire lane0 = wr_go && wstrb[0];
  wire [1:0] w1c = (lane0 && wr_evt) ? wdata[1:0] : 2'h0;

  // sticky events: set wins over clear
  wire [1:0] evt_set;
  assign evt_set[EV_FLAG_BIT] = flag_nxt && !flag_r;
  assign evt_set[EV_RESET_BIT] = lvrst_nxt && !lvrst_r;
  wire [1:0] event_nxt = (event_r & ~w1c) | evt_set;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_power_r <= CFG_POWER_RST;
      cfg_reset_r <= CFG_RESET_RST;
      cfg_stop_r <= CFG_STOP_RST;
      mask_r <= MASK_RST;
      event_r <= 2'h0;
    end else begin
      event_r <= event_nxt;
      if (lane0 && wr_cfg) begin
        cfg_power_r <= wdata[CFG_POWER_BIT];
        cfg_reset_r <= wdata[CFG_RESET_BIT];
        cfg_stop_r <= wdata[CFG_STOP_BIT];
      end
      if (lane0 && wr_msk) begin
        mask_r <= wdata[1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      awready_r <= wr_go;
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end
  assign awready = awready_r;
  assign wready = awready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;

  // read channel; status is read-only
  logic arready_r;
  logic rvalid_r;
  logic [DATA_W-1:0] rdata_r;
  logic [1:0] rresp_r;
  wire rd_go = arvalid && !arready_r && !rvalid_r;
  wire [DATA_W-1:0] sts_word = DATA_W'({lvrst_r, flag_r});
  wire [DATA_W-1:0] cfg_word = DATA_W'({cfg_stop_r, cfg_reset_r,
                                        cfg_power_r});
  wire [DATA_W-1:0] evt_word = DATA_W'(event_r);
  wire [DATA_W-1:0] msk_word = DATA_W'(mask_r);
  wire rd_map;
  wire [DATA_W-1:0] rd_word;
  assign rd_map = (araddr == STATUS_OFF) || (araddr == CONFIG_OFF) ||
                  (araddr == EVENT_OFF) || (araddr == MASK_OFF);
  assign rd_word = (araddr == STATUS_OFF) ? sts_word :
                   (araddr == CONFIG_OFF) ? cfg_word :
                   (araddr == EVENT_OFF) ? evt_word :
                   (araddr == MASK_OFF) ? msk_word : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else begin
      arready_r <= rd_go;
      if (rd_go) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_word;
        rresp_r <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // event line to the system, masked off after reset; no cpu request
  logic irq_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(event_nxt & mask_r);
    end
  end
  assign event_irq = irq_r;

  // helper run counters for checks
  logic [3:0] cpu_run;
  logic [6:0] xtal_run;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_run <= 4'h0;
      xtal_run <= 7'h00;
    end else begin
      if (!below_s) begin
        cpu_run <= 4'h0;
      end else if (cpu_tick && cpu_run != 4'hF) begin
        cpu_run <= cpu_run + 4'h1;
      end
      if (!below_s || !active || lvrst_r) begin
        xtal_run <= 7'h00;
      end else if (xtal_tick && xtal_run != 7'h7F) begin
        xtal_run <= xtal_run + 7'h01;
      end
    end
  end

  cfg_after_reset_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      $past(!aresetn) |-> cfg_power_r && cfg_reset_r && !flag_r)
    else $error("enables or flag wrong after reset");
  power_off_quiet_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      !cfg_power_r && !lvrst_r |=> !lvrst_r)
    else $error("reset raised with power enable clear");
  filter_nine_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(lvrst_r) && !$past(stop_mode) |-> $past(cpu_run) >= 4'h9)
    else $error("reset raised before nine low cycles");
  release_one_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      lvrst_r && cpu_tick && above_s |=> !lvrst_r)
    else $error("reset not released after a cycle above");
  hold_reset_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      lvrst_r && !(cpu_tick && above_s) |=> lvrst_r)
    else $error("reset released early");
  pin_follows_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      reset_pin_oe == lvrst_r && (!reset_pin_oe || !reset_pin_o))
    else $error("reset pin not driven low with reset");
  pin_release_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(lvrst_r) |-> !reset_pin_oe && reset_pin_o)
    else $error("reset pin still driven after release");
  both_enables_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(lvrst_r) |-> $past(cfg_power_r && cfg_reset_r))
    else $error("reset raised without both enables");
  polled_quiet_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      cfg_power_r && !cfg_reset_r && !lvrst_r |=> !lvrst_r)
    else $error("reset raised in polled operation");
  flag_window_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(flag_r) |-> $past(xtal_run) >= 7'h20 && $past(xtal_run) <= 7'h28)
    else $error("flag set outside 32 to 40 ticks");
  flag_late_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      xtal_run >= 7'h29 |-> flag_r)
    else $error("flag not set after 40 ticks");
  flag_clear_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      above_s |=> !flag_r)
    else $error("flag set while supply above rising trip");
  reset_clears_flag_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      lvrst_r |=> !flag_r)
    else $error("flag kept during low voltage reset");
  irq_quiet_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      mask_r == 2'h0 |=> !event_irq)
    else $error("event line raised with all events masked");
  reset_event_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(lvrst_r) |-> event_r[EV_RESET_BIT])
    else $error("reset event not recorded");
  stop_bypass_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      stop_mode && cfg_stop_r && rst_gen && below_s && !lvrst_r |=> lvrst_r)
    else $error("stop trip did not reset at once");
  stop_inactive_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      stop_mode && !cfg_stop_r && !lvrst_r |=> !lvrst_r)
    else $error("reset raised in stop without stop enable");
  bresp_hold_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      bvalid_r && !bready |=> bvalid_r && $stable(bresp_r))
    else $error("write response dropped before accept");
  rdata_hold_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      rvalid_r && !rready |=> rvalid_r && $stable(rdata_r))
    else $error("read data dropped before accept");
endmodule : lv_monitor
`default_nettype wire

/* test/supply_comparator_model.sv */
// behavioural analog supply comparator with falling and rising trips
`timescale 1ns/1ps
`default_nettype none
module supply_comparator_model #(
  parameter realtime SETTLE_NS = 7.0
) (
  // supply level: 0 below falling, 1 between trips, 2 above rising
  input wire logic [1:0] level,
  // comparator levels
  output logic below_falling_trip,
  output logic above_rising_trip
);
  // settling delay keeps level changes away from the sampling edge
  assign #SETTLE_NS below_falling_trip = (level == 2'h0);
  assign #SETTLE_NS above_rising_trip = (level == 2'h2);
endmodule : supply_comparator_model
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the supply voltage monitor
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lv_monitor_pkg::*;
  localparam logic [1:0] LOW = 2'h0;
  localparam logic [1:0] BAND = 2'h1;
  localparam logic [1:0] HIGH = 2'h2;
  localparam int LIMIT = 5000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, stop_mode = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [1:0] level = 2'h2;
  logic awready, wready, bvalid, arready, rvalid, below, above;
  logic lowvolt_reset, reset_pin_o, reset_pin_oe, event_irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int n_fail = 0, tests_run = 0, cycles = 0, n = 0;
  logic [15:0] seed = 16'hA37C;

  always #20 aclk = ~aclk;

  lv_monitor dut_u (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .below_falling_trip(below), .above_rising_trip(above),
    .stop_mode(stop_mode), .lowvolt_reset(lowvolt_reset),
    .reset_pin_o(reset_pin_o), .reset_pin_oe(reset_pin_oe),
    .event_irq(event_irq));

  supply_comparator_model cmp_u (.level(level),
    .below_falling_trip(below), .above_rising_trip(above));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask : cyc

  task automatic set_level(input logic [1:0] v);
    @(posedge aclk);
    level <= v;
  endtask : set_level

  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    bq.push_back(e);
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    rq.push_back({e, d});
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd

  // edges until the reset request shows the wanted level
  task automatic wait_rst(input logic v);
    n = 0;
    while (lowvolt_reset !== v && n < 100) begin
      @(posedge aclk);
      n++;
    end
  endtask : wait_rst

  // result watcher and hang guard
  always @(posedge aclk) begin
    cycles++;
    if (bvalid === 1'b1 && bready) check(34'(bresp), 34'(bq.pop_front()));
    if (rvalid === 1'b1 && rready) check({rresp, rdata}, rq.pop_front());
    if (cycles == LIMIT) begin
      n_fail++;
      print_verdict();
    end
  end

  initial begin
    cyc(3);
    aresetn <= 1'b1;
    rd(CONFIG_OFF, 32'h3, RESP_OKAY);
    rd(STATUS_OFF, 32'h0, RESP_OKAY);
    rd(MASK_OFF, 32'h0, RESP_OKAY);
    rd(4'h2, 32'h0, RESP_SLVERR);
    wr(4'h6, 32'h1, RESP_SLVERR);
    // random short dips separated by brief recoveries
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      set_level(LOW);
      cyc(4 * (1 + int'(seed % 16'h7)));
      set_level(BAND);
      cyc(4);
    end
    check(34'(lowvolt_reset), 34'h0);
    set_level(LOW);
    wait_rst(1'b1);
    check(34'(n >= 36 && n <= 42), 34'h1);
    check(34'({reset_pin_oe, reset_pin_o}), 34'h2);
    rd(STATUS_OFF, 32'h2, RESP_OKAY);
    set_level(BAND);
    cyc(20);
    check(34'(lowvolt_reset), 34'h1);
    set_level(HIGH);
    wait_rst(1'b0);
    check(34'(n <= 9), 34'h1);
    check(34'({reset_pin_oe, reset_pin_o}), 34'h1);
    rd(EVENT_OFF, 32'h2, RESP_OKAY);
    // polled operation with random upper config bits
    seed = lfsr(seed);
    wr(CONFIG_OFF, {seed, 16'h1}, RESP_OKAY);
    rd(CONFIG_OFF, 32'h1, RESP_OKAY);
    wr(EVENT_OFF, 32'h3, RESP_OKAY);
    set_level(LOW);
    cyc(48);
    rd(STATUS_OFF, 32'h0, RESP_OKAY);
    cyc(46);
    rd(STATUS_OFF, 32'h1, RESP_OKAY);
    check(34'(lowvolt_reset), 34'h0);
    set_level(BAND);
    wr(STATUS_OFF, 32'h0, RESP_OKAY);
    rd(STATUS_OFF, 32'h1, RESP_OKAY);
    check(34'(event_irq), 34'h0);
    wr(MASK_OFF, 32'h1, RESP_OKAY);
    cyc(2);
    check(34'(event_irq), 34'h1);
    wr(EVENT_OFF, 32'h1, RESP_OKAY);
    cyc(2);
    check(34'(event_irq), 34'h0);
    set_level(HIGH);
    cyc(6);
    rd(STATUS_OFF, 32'h0, RESP_OKAY);
    set_level(LOW);
    cyc(90);
    rd(STATUS_OFF, 32'h1, RESP_OKAY);
    aresetn <= 1'b0;
    cyc(3);
    aresetn <= 1'b1;
    rd(STATUS_OFF, 32'h0, RESP_OKAY);
    wr(CONFIG_OFF, 32'h0, RESP_OKAY);
    cyc(100);
    check(34'(lowvolt_reset), 34'h0);
    rd(STATUS_OFF, 32'h0, RESP_OKAY);
    // stop mode without and with its enable
    set_level(HIGH);
    wr(CONFIG_OFF, 32'h3, RESP_OKAY);
    stop_mode <= 1'b1;
    set_level(LOW);
    cyc(60);
    check(34'(lowvolt_reset), 34'h0);
    set_level(HIGH);
    cyc(6);
    stop_mode <= 1'b0;
    wr(CONFIG_OFF, 32'h7, RESP_OKAY);
    stop_mode <= 1'b1;
    set_level(LOW);
    wait_rst(1'b1);
    check(34'(n >= 3 && n <= 6), 34'h1);
    set_level(HIGH);
    stop_mode <= 1'b0;
    wait_rst(1'b0);
    check(34'(n <= 9), 34'h1);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
